// *** core/aisc_pkg.sv ***
// Package of constants and types for the idle and SMART command unit.
package aisc_pkg;
  // ---------------------------------------------------------------------
  // Register map (APB byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_SUBCMD = 8'h00;
  localparam logic [7:0] ADDR_SECCNT = 8'h04;
  localparam logic [7:0] ADDR_BALOW = 8'h08;
  localparam logic [7:0] ADDR_BAMID = 8'h0C;
  localparam logic [7:0] ADDR_BAHIGH = 8'h10;
  localparam logic [7:0] ADDR_DRVSEL = 8'h14;
  localparam logic [7:0] ADDR_CMD = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_ERROR = 8'h20;
  localparam logic [7:0] ADDR_SMART_SEL = 8'h24;
  localparam logic [7:0] ADDR_SMART_DATA = 8'h28;
  localparam logic [7:0] ADDR_HWRESULT = 8'h2C;
  localparam logic [7:0] ADDR_ID_WORD = 8'h30;
  localparam logic [7:0] ADDR_MODE = 8'h34;
  localparam logic [7:0] ADDR_STATS_A = 8'h38;
  localparam logic [7:0] ADDR_STATS_B = 8'h3C;
  localparam logic [7:0] ADDR_STATS_C = 8'h40;
  localparam logic [7:0] ADDR_HWINFO = 8'h44;
  localparam logic [7:0] ADDR_SECURITY = 8'h48;
  localparam logic [7:0] ADDR_SECTOR_FMT = 8'h4C;
  // ---------------------------------------------------------------------
  // Command codes, sub-functions and signatures
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE = 8'hE3;
  localparam logic [7:0] CMD_IDLE_NOW = 8'hE1;
  localparam logic [7:0] CMD_SMART = 8'hB0;
  localparam logic [7:0] SUB_READ = 8'hD0;
  localparam logic [7:0] SUB_ENABLE = 8'hD8;
  localparam logic [7:0] SUB_DISABLE = 8'hD9;
  localparam logic [7:0] SIG_MID = 8'h4F;
  localparam logic [7:0] SIG_HIGH = 8'hC2;
  localparam logic [7:0] REC_ECC = 8'hE9;
  localparam logic [7:0] REC_ERASE = 8'hEA;
  localparam logic [7:0] REC_BLOCK = 8'hEB;
  // ---------------------------------------------------------------------
  // Status and error bit positions, reset values
  // ---------------------------------------------------------------------
  localparam int ST_ERR = 0;
  localparam int ST_DRQ = 3;
  localparam int ST_DF = 5;
  localparam int ST_DRDY = 6;
  localparam int ST_BSY = 7;
  localparam int ER_ABRT = 2;
  localparam int DEV_BIT = 4;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  localparam logic [15:0] SECTOR_FMT_RESET = 16'h4000;
  localparam logic [23:0] FREE_MIN = 24'd20;
  localparam logic [8:0] SECURITY_RESET = 9'h021;
  localparam logic [15:0] HW_RESULT_RESET = 16'h4000;
  localparam logic [23:0] FREE_RESET = 24'hFFFFFF;
  // ---------------------------------------------------------------------
  // Timer encoding and timing
  // ---------------------------------------------------------------------
  localparam logic [7:0] TMR_OFF = 8'h00;
  localparam logic [7:0] TMR_SEC_MAX = 8'hF0;
  localparam logic [7:0] TMR_HALF_MAX = 8'hFB;
  localparam logic [7:0] TMR_21M = 8'hFC;
  localparam logic [7:0] TMR_LONG = 8'hFD;
  localparam logic [7:0] TMR_RSVD = 8'hFE;
  localparam logic [7:0] TMR_21M15 = 8'hFF;
  localparam logic [7:0] TMR_BASE = 8'd240;
  localparam int CLK_HZ = 100_000_000;
  localparam int SEC_PER_STEP = 5;
  localparam int SEC_PER_HALF = 1800;
  localparam int SEC_21M = 1260;
  localparam int SEC_LONG = 36000;
  localparam int SEC_21M15 = 1275;
  localparam int TICK_PER_SEC = CLK_HZ;

  typedef enum logic [1:0] {
    AISC_ACTIVE = 2'b00,
    AISC_IDLE = 2'b01,
    AISC_STANDBY = 2'b10
  } aisc_mode_t;
endpackage : aisc_pkg

// *** core/aisc_top.sv ***
// Idle, idle-immediate and SMART command unit with an APB register file.
// Functional notes
// [RULE1] E3h enters idle and loads standby timer from sector count.
// [RULE2] Timer 0 off, 1-240 times 5 s, 241-251 (v-240) times 30 min.
// [RULE3] 252 is 21 min, 253 is 8-12 h, 255 is 21m15s, 254 reserved.
// [RULE4] E1h enters idle at once, timer unchanged, uses drive select; the code stores drive select but never uses it.
// [RULE5] Normal completion clears BSY, DF, DRQ, ERR and sets DRDY.
// [RULE6] Failed idle sets abort bit 2 and status error bit.
// [RULE7] B0h picks its SMART sub-function from the features value.
// [RULE8] D0h read data, D8h enable, D9h disable.
// [RULE9] Host loads mid 4Fh and high C2h for every SMART command.
// [RULE10] SMART read accepted only with DRDY set and SMART enabled.
// [RULE11] SMART read returns records E9, EA, EB of eight bytes.
// [RULE12] E9 holds threshold, row address, channel, bank, reserved.
// [RULE13] EA holds 24-bit average and maximum erase counts, high first.
// [RULE14] EB holds used block count then free block count.
// [RULE15] Device locks when free block count falls below 20.
// [RULE16] Reset result bits 12:0 change only during hardware reset.
// [RULE17] Bit 13 reports cable-identify line level.
// [RULE18] Numbering method: 01 jumper, 10 cable select, 11 other.
// [RULE19] Device 0 fills bits 7-0, device 1 fills bits 12-8.
// [RULE20] Device 0 bits: 0 set, 3 pass, 4 diag, 5 active, 6 respond.
// [RULE21] Word 128 reports security supported, state bits and level.
// [RULE22] Word 106: 15 zero, 14 one, bits 13, 12 and ratio 3-0.
// [RULE23] Expired standby timer moves idle mode to standby mode.
// [RULE24] Bad sub-function or signature aborts the SMART command.
module aisc_top
  import aisc_pkg::*;
#(
  parameter int TICKS_PER_SEC = TICK_PER_SEC
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic HW_RESET_ACTIVE_IN,
  input wire logic CABLE_ID_HIGH_IN,
  input wire logic IS_DEVICE1_IN,
  input wire logic [1:0] NUMBER_METHOD_IN,
  input wire logic DIAG_LINE_IN,
  input wire logic ACTIVE_LINE_IN,
  input wire logic DIAG_PASS_IN,
  input wire logic RESPONDS_DEV1_IN,
  output logic [1:0] POWER_MODE_OUT,
  output logic LOCKED_OUT
);

  typedef struct packed {
    logic [7:0] subcmd;
    logic [7:0] seccnt;
    logic [7:0] balow;
    logic [7:0] bamid;
    logic [7:0] bahigh;
    logic [7:0] drvsel;
    logic [7:0] status;
    logic [7:0] error;
    logic smart_en;
    aisc_mode_t mode;
    logic [63:0] timer_ticks;
    logic [63:0] timer_cnt;
    logic [7:0] ecc_thr;
    logic [23:0] row_addr;
    logic [7:0] chan;
    logic [7:0] bank;
    logic [23:0] avg_erase;
    logic [23:0] max_erase;
    logic [23:0] used_blk;
    logic [23:0] free_blk;
    logic [4:0] smart_idx;
    logic locked;
    logic [15:0] hw_result;
    logic [8:0] security;
    logic [15:0] sector_fmt;
    logic [31:0] prdata;
  } aisc_state_t;

  aisc_state_t q;
  aisc_state_t d;

  // ---------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------
  // Standby period in seconds; zero means no timeout.
  function automatic logic [31:0] timer_secs(input logic [7:0] v);
    logic [31:0] s;
    s = 32'd0;
    if (v == TMR_OFF) begin // [RULE2]
      s = 32'd0;
    end else if (v <= TMR_SEC_MAX) begin // [RULE2]
      s = 32'(v) * 32'(SEC_PER_STEP);
    end else if (v <= TMR_HALF_MAX) begin // [RULE2]
      s = 32'(v - TMR_BASE) * 32'(SEC_PER_HALF);
    end else if (v == TMR_21M) begin // [RULE3]
      s = 32'(SEC_21M);
    end else if (v == TMR_LONG) begin // [RULE3]
      s = 32'(SEC_LONG);
    end else if (v == TMR_21M15) begin // [RULE3]
      s = 32'(SEC_21M15);
    end
    return s;
  endfunction

  // One byte of the 24-byte SMART structure, records in ID order.
  function automatic logic [7:0] smart_byte(input aisc_state_t s,
                                            input logic [4:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      5'd0: b = s.ecc_thr; // [RULE12]
      5'd1: b = s.row_addr[23:16];
      5'd2: b = s.row_addr[15:8];
      5'd3: b = s.row_addr[7:0];
      5'd4: b = s.chan;
      5'd5: b = s.bank;
      5'd8: b = s.avg_erase[23:16]; // [RULE13]
      5'd9: b = s.avg_erase[15:8];
      5'd10: b = s.avg_erase[7:0];
      5'd11: b = s.max_erase[23:16];
      5'd12: b = s.max_erase[15:8];
      5'd13: b = s.max_erase[7:0];
      5'd16: b = s.used_blk[23:16]; // [RULE14]
      5'd17: b = s.used_blk[15:8];
      5'd18: b = s.used_blk[7:0];
      5'd19: b = s.free_blk[23:16];
      5'd20: b = s.free_blk[15:8];
      5'd21: b = s.free_blk[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // Finished command: clean completion or abort.
  function automatic logic [7:0] done_status(input logic err);
    logic [7:0] st;
    st = 8'h00;
    st[ST_DRDY] = 1'b1; // [RULE5]
    st[ST_ERR] = err; // [RULE6]
    return st;
  endfunction

  // Record identity of a byte position in the SMART structure.
  function automatic logic [7:0] rec_of(input logic [4:0] i);
    logic [7:0] r;
    r = REC_BLOCK;
    if (i < 5'd8) begin
      r = REC_ECC;
    end else if (i < 5'd16) begin
      r = REC_ERASE;
    end
    return r;
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic [7:0] cmd;
  logic sig_ok;
  logic [63:0] ticks;
  logic [7:0] rec_id;

  // Reads are decoded in the setup cycle and writes in the access cycle.
  // With ready tied high every transfer takes exactly two cycles.
  assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_acc = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign cmd = PWDATA_IN[7:0];
  assign sig_ok = (q.bamid == SIG_MID) && (q.bahigh == SIG_HIGH); // [RULE9]
  assign ticks = 64'(timer_secs(q.seccnt)) * 64'(TICKS_PER_SEC);
  assign rec_id = rec_of(q.smart_idx);

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  always_comb begin
    d = q;
    // -------------------------------------------------------------------
    // Standby timer and lock
    // -------------------------------------------------------------------
    // Standby timer runs only in idle mode with a non-zero period.
    if (q.mode == AISC_IDLE && q.timer_ticks != 64'd0) begin
      if (q.timer_cnt + 64'd1 >= q.timer_ticks) begin
        d.mode = AISC_STANDBY; // [RULE23]
        d.timer_cnt = 64'd0;
      end else begin
        d.timer_cnt = q.timer_cnt + 64'd1;
      end
    end
    d.locked = (q.free_blk < FREE_MIN); // [RULE15]
    // -------------------------------------------------------------------
    // Hardware reset result
    // -------------------------------------------------------------------
    // Reset result is captured only while the hardware reset runs.
    if (HW_RESET_ACTIVE_IN) begin // [RULE16]
      d.hw_result = 16'h0000;
      d.hw_result[14] = 1'b1; // [RULE16]
      d.hw_result[13] = CABLE_ID_HIGH_IN; // [RULE17]
      if (IS_DEVICE1_IN) begin // [RULE19]
        d.hw_result[11] = DIAG_LINE_IN;
        d.hw_result[10:9] = NUMBER_METHOD_IN; // [RULE18]
        d.hw_result[8] = 1'b1;
      end else begin // [RULE20]
        d.hw_result[6] = RESPONDS_DEV1_IN;
        d.hw_result[5] = ACTIVE_LINE_IN;
        d.hw_result[4] = DIAG_LINE_IN;
        d.hw_result[3] = DIAG_PASS_IN;
        d.hw_result[2:1] = NUMBER_METHOD_IN; // [RULE18]
        d.hw_result[0] = 1'b1;
      end
    end
    // -------------------------------------------------------------------
    // Register writes and commands
    // -------------------------------------------------------------------
    if (wr_acc) begin
      case (PADDR_IN)
        ADDR_SUBCMD: d.subcmd = cmd;
        ADDR_SECCNT: d.seccnt = cmd;
        ADDR_BALOW: d.balow = cmd;
        ADDR_BAMID: d.bamid = cmd;
        ADDR_BAHIGH: d.bahigh = cmd;
        ADDR_DRVSEL: d.drvsel = cmd;
        ADDR_SMART_SEL: d.smart_idx = PWDATA_IN[4:0];
        ADDR_STATS_A: begin
          d.ecc_thr = PWDATA_IN[31:24];
          d.row_addr = PWDATA_IN[23:0];
        end
        ADDR_STATS_B: begin
          d.avg_erase = PWDATA_IN[23:0];
          d.chan = PWDATA_IN[31:24];
        end
        ADDR_STATS_C: begin
          d.max_erase = PWDATA_IN[23:0];
          d.bank = PWDATA_IN[31:24];
        end
        ADDR_HWINFO: begin
          d.used_blk = PWDATA_IN[23:0];
        end
        ADDR_MODE: begin
          d.free_blk = PWDATA_IN[23:0];
        end
        ADDR_SECURITY: d.security = PWDATA_IN[8:0]; // [RULE21]
        ADDR_SECTOR_FMT: begin
          d.sector_fmt = {2'b01, PWDATA_IN[13:12], 8'h00,
                          PWDATA_IN[3:0]}; // [RULE22]
        end
        ADDR_CMD: begin
          // Commands finish in the cycle that takes them, so BSY never shows.
          // Status and error are rebuilt for every command.
          d.error = 8'h00;
          d.status = done_status(1'b0); // [RULE5]
          case (cmd)
            CMD_IDLE: begin
              if (q.status[ST_DRDY] && q.seccnt != TMR_RSVD) begin
                d.mode = AISC_IDLE; // [RULE1]
                d.timer_ticks = ticks;
                d.timer_cnt = 64'd0;
              end else begin
                d.error[ER_ABRT] = 1'b1; // [RULE6]
                d.status = done_status(1'b1);
              end
            end
            CMD_IDLE_NOW: begin
              if (q.status[ST_DRDY]) begin
                d.mode = AISC_IDLE; // [RULE4]
                d.timer_cnt = 64'd0;
              end else begin
                d.error[ER_ABRT] = 1'b1; // [RULE6]
                d.status = done_status(1'b1);
              end
            end
            // A SMART command counts as activity and wakes a standby device.
            CMD_SMART: begin
              d.mode = (q.mode == AISC_STANDBY) ? AISC_IDLE : q.mode;
              d.timer_cnt = 64'd0;
              case (q.subcmd) // [RULE7]
                SUB_READ: begin // [RULE8]
                  if (sig_ok && q.smart_en && q.status[ST_DRDY]) begin
                    d.smart_idx = 5'd0; // [RULE10]
                  end else begin
                    d.error[ER_ABRT] = 1'b1; // [RULE24]
                    d.status = done_status(1'b1);
                  end
                end
                SUB_ENABLE: begin // [RULE8]
                  if (sig_ok) begin
                    d.smart_en = 1'b1;
                  end else begin
                    d.error[ER_ABRT] = 1'b1; // [RULE24]
                    d.status = done_status(1'b1);
                  end
                end
                SUB_DISABLE: begin // [RULE8]
                  if (sig_ok && q.smart_en) begin
                    d.smart_en = 1'b0;
                  end else begin
                    d.error[ER_ABRT] = 1'b1; // [RULE24]
                    d.status = done_status(1'b1);
                  end
                end
                default: begin
                  d.error[ER_ABRT] = 1'b1; // [RULE24]
                  d.status = done_status(1'b1);
                end
              endcase
            end
            default: begin
              d.error[ER_ABRT] = 1'b1;
              d.status = done_status(1'b1);
            end
          endcase
        end
        default: d.prdata = q.prdata;
      endcase
    end
    // -------------------------------------------------------------------
    // Register reads
    // -------------------------------------------------------------------
    // Read data is prepared in the setup cycle so it is a flop output.
    if (rd_acc) begin
      case (PADDR_IN)
        ADDR_SECCNT: d.prdata = {24'h0, q.seccnt};
        ADDR_BALOW: d.prdata = {24'h0, q.balow};
        ADDR_BAMID: d.prdata = {24'h0, q.bamid};
        ADDR_BAHIGH: d.prdata = {24'h0, q.bahigh};
        ADDR_DRVSEL: d.prdata = {24'h0, q.drvsel}; // [RULE4]
        ADDR_STATUS: d.prdata = {24'h0, q.status};
        ADDR_ERROR: d.prdata = {24'h0, q.error};
        ADDR_SMART_SEL: d.prdata = {27'h0, q.smart_idx};
        ADDR_SMART_DATA: begin
          d.prdata = {16'h0, rec_id, smart_byte(q, q.smart_idx)}; // [RULE11]
          // The index steps only while SMART is enabled; a disabled device
          // keeps returning the same byte.
          if (q.smart_en) begin
            d.smart_idx = (q.smart_idx == 5'd23) ? 5'd0 :
                          q.smart_idx + 5'd1;
          end
        end
        ADDR_HWRESULT: d.prdata = {16'h0, q.hw_result};
        ADDR_ID_WORD: d.prdata = {16'h0, q.hw_result};
        ADDR_MODE: d.prdata = {q.locked, 28'h0, q.smart_en, q.mode};
        ADDR_SECURITY: d.prdata = {23'h0, q.security}; // [RULE21]
        ADDR_SECTOR_FMT: d.prdata = {16'h0, q.sector_fmt}; // [RULE22]
        default: d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      q <= '0;
      q.status <= STATUS_RESET;
      q.mode <= AISC_ACTIVE;
      q.sector_fmt <= SECTOR_FMT_RESET;
      q.security <= SECURITY_RESET;
      q.hw_result <= HW_RESULT_RESET;
      q.free_blk <= FREE_RESET;
    end else begin
      q <= d;
    end
  end

  // Every register answers without wait states.
  assign PREADY_OUT = 1'b1;
  // Refused commands are reported in the error register, never on the bus.
  assign PSLVERR_OUT = 1'b0;
  assign PRDATA_OUT = q.prdata;
  assign POWER_MODE_OUT = q.mode;
  assign LOCKED_OUT = q.locked;

endmodule // aisc_top

// *** testbench/aisc_props.sv ***
// Concurrent checks on the ports of the idle and SMART command unit.
module aisc_props
  import aisc_pkg::*;
#(
  parameter int TICKS_PER_SEC = 10
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [1:0] POWER_MODE_OUT,
  input wire logic LOCKED_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);
  logic wr_c;
  logic rd_s;
  assign wr_c = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_s = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  // ---------------------------------------------------------------
  // Bus and command behaviour
  // ---------------------------------------------------------------
  a_ready_high: assert property (PREADY_OUT) else $error("ready low");
  a_no_slverr: assert property (!PSLVERR_OUT) else $error("slverr");
  a_idle_now_mode: assert property (wr_c && PADDR_IN == ADDR_CMD &&
    PWDATA_IN[7:0] == CMD_IDLE_NOW |=> POWER_MODE_OUT == AISC_IDLE)
    else $error("no idle after idle now");
  a_mode_legal: assert property (POWER_MODE_OUT != 2'b11)
    else $error("bad mode");
  a_standby_entry: assert property (
    $rose(POWER_MODE_OUT == AISC_STANDBY)
    |-> $past(POWER_MODE_OUT) == AISC_IDLE) else $error("bad standby");
  // The lock follows the written free count two cycles after the write.
  property p_lock;
    wr_c && PADDR_IN == ADDR_MODE
      |-> ##2 LOCKED_OUT == ($past(PWDATA_IN[23:0], 2) < FREE_MIN);
  endproperty
  a_lock_free: assert property (p_lock) else $error("lock wrong");
  a_rdata_hold: assert property (!rd_s |=> $stable(PRDATA_OUT))
    else $error("read data moved");
  a_hw_fixed: assert property (rd_s && PADDR_IN == ADDR_HWRESULT
    |=> PRDATA_OUT[15:14] == 2'b01) else $error("reset word top");
  a_fmt_fixed: assert property (rd_s && PADDR_IN == ADDR_SECTOR_FMT
    |=> PRDATA_OUT[15:14] == 2'b01) else $error("format top");
  a_status_done: assert property (rd_s && PADDR_IN == ADDR_STATUS
    |=> !PRDATA_OUT[ST_BSY] && PRDATA_OUT[ST_DRDY]) else $error("busy");
  c_standby: cover property (POWER_MODE_OUT == AISC_STANDBY);
  c_locked: cover property ($rose(LOCKED_OUT));
  c_smart: cover property (wr_c && PADDR_IN == ADDR_CMD &&
    PWDATA_IN[7:0] == CMD_SMART);
endmodule // aisc_props

// *** testbench/aisc_host_model.sv ***
// Host controller model that issues task-file commands over APB.
module aisc_host_model
  import aisc_pkg::*;
(
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [7:0] paddr_out,
  output logic [31:0] pwdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // Each transfer starts one edge after the last so no signal is set twice
  // in one time step.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    do @(posedge clk_in); while (pready_in !== 1'b1);
    q = prdata_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  // The timer value is placed before the command code is written.
  task automatic idle(input logic [7:0] t);
    wr(ADDR_SECCNT, {24'h0, t});
    wr(ADDR_CMD, {24'h0, CMD_IDLE});
  endtask
  task automatic smart(input logic [7:0] f, input logic [7:0] m,
                       input logic [7:0] h);
    wr(ADDR_SUBCMD, {24'h0, f});
    wr(ADDR_BAMID, {24'h0, m});
    wr(ADDR_BAHIGH, {24'h0, h});
    wr(ADDR_CMD, {24'h0, CMD_SMART});
  endtask
endmodule // aisc_host_model

// *** testbench/ata_idle_smart_command_unit_tb_top.sv ***
// Self-checking bench for the idle and SMART command unit.
module ata_idle_smart_command_unit_tb_top;
  import aisc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // A short second keeps the longest timer within the run.
  localparam int TPS = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, locked;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic hw_rst = 1'b0;
  logic dev1 = 1'b0;
  logic cab = 1'b0;
  logic diag = 1'b0;
  logic act = 1'b0;
  logic pass = 1'b0;
  logic resp = 1'b0;
  logic [1:0] meth = 2'b01;
  logic [1:0] mode;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] tv [5] = '{8'h01, 8'hF0, 8'hF1, 8'hFC, 8'hFF};
  int ts [5] = '{5, 1200, 1800, 1260, 1275};
  logic [7:0] rb [24] = '{8'hA1, 8'h12, 8'h34, 8'h56, 8'h05, 8'h03, 8'h00,
    8'h00, 8'h0A, 8'hBC, 8'hDE, 8'h0F, 8'h1E, 8'h2D, 8'h00, 8'h00, 8'h00,
    8'hC0, 8'hDE, 8'h01, 8'h23, 8'h45, 8'h00, 8'h00};
  always #5 clk = ~clk;
  aisc_top #(.TICKS_PER_SEC(TPS)) DUT (
    .CORE_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .HW_RESET_ACTIVE_IN(hw_rst),
    .CABLE_ID_HIGH_IN(cab), .IS_DEVICE1_IN(dev1), .NUMBER_METHOD_IN(meth),
    .DIAG_LINE_IN(diag), .ACTIVE_LINE_IN(act), .DIAG_PASS_IN(pass),
    .RESPONDS_DEV1_IN(resp), .POWER_MODE_OUT(mode), .LOCKED_OUT(locked));
  aisc_host_model host (
    .clk_in(clk), .prdata_in(prdata), .pready_in(pready),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    host.rd(a, q);
    ck(q & m, e);
  endtask
  task automatic ckm(input aisc_mode_t e);
    ck({30'h0, mode}, {30'h0, e});
  endtask
  task automatic hw_case(input logic [7:0] p, input logic [15:0] e);
    hw_rst <= 1'b1;
    {dev1, cab, meth, diag, act, pass, resp} <= p;
    repeat (3) @(posedge clk);
    hw_rst <= 1'b0;
    rc(ADDR_HWRESULT, 32'hFFFF, {16'h0, e});
    {dev1, cab, meth, diag, act, pass, resp} <= ~p;
    rc(ADDR_HWRESULT, 32'hFFFF, {16'h0, e});
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    ckm(AISC_ACTIVE);
    rc(ADDR_STATUS, 32'hFF, {24'h0, STATUS_RESET});
    rc(ADDR_SECURITY, 32'h1FF, {23'h0, SECURITY_RESET});
    rc(ADDR_SECTOR_FMT, 32'hFFFF, {16'h0, SECTOR_FMT_RESET});
    host.wr(ADDR_SECTOR_FMT, 32'hFFFFFFFF);
    rc(ADDR_SECTOR_FMT, 32'hFFFF, 32'h700F);
    rc(8'h50, 32'hFFFFFFFF, 32'h0);
    host.wr(ADDR_DRVSEL, 32'h0);
    host.wr(ADDR_CMD, {24'h0, CMD_IDLE_NOW});
    @(posedge clk);
    ckm(AISC_IDLE);
    // Each expiry is checked a few cycles before and after its period.
    foreach (tv[i]) begin
      host.idle(tv[i]);
      rc(ADDR_STATUS, 32'hFF, 32'h40);
      repeat (ts[i] * TPS - 17) @(posedge clk);
      ckm(AISC_IDLE);
      repeat (26) @(posedge clk);
      ckm(AISC_STANDBY);
    end
    host.idle(8'h00);
    repeat (200) @(posedge clk);
    ckm(AISC_IDLE);
    host.idle(8'h01);
    host.wr(ADDR_SECCNT, 32'h0);
    host.wr(ADDR_CMD, {24'h0, CMD_IDLE_NOW});
    repeat (33) @(posedge clk);
    ckm(AISC_IDLE);
    repeat (26) @(posedge clk);
    ckm(AISC_STANDBY);
    host.idle(TMR_RSVD);
    rc(ADDR_STATUS, 32'h81, 32'h01);
    rc(ADDR_ERROR, 32'h04, 32'h04);
    host.smart(SUB_ENABLE, SIG_MID, SIG_HIGH);
    rc(ADDR_STATUS, 32'hFF, 32'h40);
    rc(ADDR_MODE, 32'h4, 32'h4);
    host.smart(SUB_ENABLE, 8'h4E, SIG_HIGH);
    rc(ADDR_STATUS, 32'h81, 32'h01);
    host.smart(SUB_ENABLE, SIG_MID, SIG_HIGH);
    rc(ADDR_STATUS, 32'hFF, 32'h40);
    host.smart(8'hD5, SIG_MID, SIG_HIGH);
    rc(ADDR_STATUS, 32'h81, 32'h01);
    rc(ADDR_ERROR, 32'h04, 32'h04);
    host.wr(ADDR_STATS_A, 32'hA1123456);
    host.wr(ADDR_STATS_B, 32'h050ABCDE);
    host.wr(ADDR_STATS_C, 32'h030F1E2D);
    host.wr(ADDR_HWINFO, 32'h0000C0DE);
    host.wr(ADDR_MODE, 32'h00012345);
    host.smart(SUB_READ, SIG_MID, SIG_HIGH);
    rc(ADDR_STATUS, 32'hFF, 32'h40);
    host.wr(ADDR_SMART_SEL, 32'h0);
    for (int i = 0; i < 25; i++) begin
      rc(ADDR_SMART_DATA, 32'hFFFF, {16'h0, REC_ECC + 8'((i % 24) / 8),
         rb[i % 24]});
    end
    host.smart(SUB_DISABLE, SIG_MID, SIG_HIGH);
    rc(ADDR_MODE, 32'h4, 32'h0);
    host.wr(ADDR_MODE, 32'd19);
    repeat (2) @(posedge clk);
    ck({31'h0, locked}, 32'h1);
    host.wr(ADDR_MODE, 32'd20);
    repeat (2) @(posedge clk);
    ck({31'h0, locked}, 32'h0);
    hw_case(8'h6B, 16'h605D);
    hw_case(8'hB8, 16'h4F00);
    hw_case(8'h14, 16'h4023);
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // ata_idle_smart_command_unit_tb_top

bind aisc_top aisc_props #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_props (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .POWER_MODE_OUT(POWER_MODE_OUT),
  .LOCKED_OUT(LOCKED_OUT));
